// >>> hdl/vhzl_params.svh
// Purpose: constants of the overexcitation event logger
// Assumes: 125 MHz REF_CLK, 5 ms program cycle
// Notes:   delays and remaining times count in 5 ms program cycles
`ifndef VHZL_PARAMS_SVH
`define VHZL_PARAMS_SVH
`define VHZL_CLK_NS 8
`define VHZL_CYCLE_MS 5
`define VHZL_CYCLE_TICKS ((`VHZL_CYCLE_MS * 1000000) / `VHZL_CLK_NS)
`define VHZL_PRE_TRIG_MS 20
`define VHZL_PRE_FAULT_MS 200
`define VHZL_PRE_TRIG_CYC (`VHZL_PRE_TRIG_MS / `VHZL_CYCLE_MS)
`define VHZL_HIST_DEPTH (`VHZL_PRE_FAULT_MS / `VHZL_CYCLE_MS)
`define VHZL_REC_DEPTH 12
`define VHZL_RESET_PCT 97
`define VHZL_FULL_PCT 10000
`define VHZL_NOM_FREQ_MHZ 50000
`define VHZL_PU_MILLI 1000
`define VHZL_NOM_VHZ ((`VHZL_PU_MILLI * 1000) / `VHZL_NOM_FREQ_MHZ)
`define VHZL_MAX_DELAY 360000
// Register byte offsets
`define VHZL_OFF_CTRL 8'h00
`define VHZL_OFF_EVT_CFG 8'h04
`define VHZL_OFF_PICKUP 8'h08
`define VHZL_OFF_ALM_DLY 8'h0C
`define VHZL_OFF_OP_DLY 8'h10
`define VHZL_OFF_MODE 8'h14
`define VHZL_OFF_STATUS 8'h18
`define VHZL_OFF_CNT_START 8'h1C
`define VHZL_OFF_CNT_TRIP 8'h20
`define VHZL_OFF_CNT_BLK 8'h24
`define VHZL_OFF_VHZ_NOW 8'h28
`define VHZL_OFF_VHZ_NOM 8'h2C
`define VHZL_OFF_RATIO 8'h30
`define VHZL_OFF_EXP_TIME 8'h34
`define VHZL_OFF_REMAIN 8'h38
`define VHZL_OFF_REC_CNT 8'h3C
`define VHZL_OFF_REC_SEL 8'h40
`define VHZL_OFF_REC_WIN 8'h80
`define VHZL_REC_WORDS 9
// Field positions
`define VHZL_CTRL_CLR_BIT 0
`define VHZL_MODE_BEH_LSB 0
`define VHZL_MODE_INDIV_BIT 3
`define VHZL_MODE_GRP_LSB 4
// Reset values
`define VHZL_RST_EVT_CFG 8'hFF
`define VHZL_RST_PICKUP 16'h01F4
`define VHZL_RST_DLY 19'h00008
`define VHZL_RST_GRP 3'h0
`endif

// >>> hdl/vhzl_pkg.sv
// Purpose: types of the overexcitation event logger
// Assumes: nothing beyond the params header
// Notes:   record layout is nine 32-bit words, word 0 lowest
package vhzl_pkg;
   typedef enum logic [2:0] {VHZL_NORMAL, VHZL_START, VHZL_ALARM,
      VHZL_TRIP, VHZL_BLOCKED} vhzl_cond_t;
   typedef enum logic [2:0] {VHZL_BEH_ON, VHZL_BEH_BLK, VHZL_BEH_TEST,
      VHZL_BEH_TEST_BLK, VHZL_BEH_OFF} vhzl_beh_t;
   typedef enum logic [1:0] {VHZL_PH_IDLE, VHZL_PH_DIV_VHZ,
      VHZL_PH_DIV_RAT, VHZL_PH_EVAL} vhzl_phase_t;
   typedef struct packed {
      logic [8:0] pad_hi;
      logic [3:0] grp;
      logic [18:0] remain;
      logic [63:0] prefault;
      logic [63:0] fault;
      logic [63:0] pretrig;
      logic [13:0] pad_lo;
      logic [1:0] ev;
      logic [47:0] stamp;
   } vhzl_rec_t;
endpackage : vhzl_pkg

// >>> hdl/vhzl_logger.sv
// Purpose: supervision, blocking, events and fault records of one
//          volts-per-hertz overexcitation stage
// Assumes: measurements and time stamp come from logic on REF_CLK;
//          blocking input is asynchronous
// Notes:   inverse curve is outside; only definite time is timed
// Contract
// - sample blocking once per program cycle
// - pick-up without block raises start, timing
// - pick-up with block raises blocked only
// - block during start resets as pick-up
// - ON and OFF event per condition change
// - per event type select ON, OFF, both
// - events carry time stamp
// - start, trip, blocked counters, explicit clear
// - keep twelve newest fault records
// - record on start, trip, blocked ON
// - record time, event, voltages, frequency history
// - record remaining time and setting group
// - live condition, one of five
// - signed remaining time in 5 ms steps
// - expected operate time in 5 ms steps
// - behaviour shown when individual mode enabled
// - present V/Hz and ratio, 0.001 steps
// - nominal V/Hz is pu over nominal frequency
// - condition outputs as binary signals
// - release below 97 percent of pick-up
// - pick-up on largest voltage over frequency
//
// The placing of the registers and register access over Wishbone were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "vhzl_params.svh"
module vhzl_logger
   import vhzl_pkg::*;
#(
   parameter int CYC_TICKS = `VHZL_CYCLE_TICKS
) (
   input wire logic REF_CLK,
   input wire logic RST_N,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [7:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O,
   input wire logic BLOCK_IN,
   input wire logic [15:0] U_AB,
   input wire logic [15:0] U_BC,
   input wire logic [15:0] U_CA,
   input wire logic [15:0] FREQ,
   input wire logic [47:0] TIME_MS,
   output logic STAGE_START,
   output logic STAGE_ALARM,
   output logic STAGE_TRIP,
   output logic STAGE_BLOCKED,
   output logic [7:0] EVT_VALID,
   output logic [47:0] EVT_STAMP
);
   localparam int HD = `VHZL_HIST_DEPTH;
   localparam int RD = `VHZL_REC_DEPTH;

   function automatic logic [15:0] max3(input logic [15:0] a,
      input logic [15:0] b, input logic [15:0] c);
      logic [15:0] m;
      m = (a > b) ? a : b;
      return (c > m) ? c : m;
   endfunction : max3

   function automatic logic [5:0] hist_back(input logic [5:0] p,
      input logic [5:0] n);
      return (p >= n) ? 6'(p - n) : 6'(p + 6'(HD) - n);
   endfunction : hist_back

   function automatic logic [3:0] rec_newest(input logic [3:0] wp,
      input logic [3:0] sel);
      logic [4:0] t;
      t = 5'({1'b0, wp} + 5'(RD) - 5'h01 - {1'b0, sel});
      return (t >= 5'(RD)) ? 4'(t - 5'(RD)) : t[3:0];
   endfunction : rec_newest

   function automatic logic [31:0] wb_merge(input logic [31:0] old,
      input logic [31:0] dat, input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = dat[i*8 +: 8];
         end
      end
      return r;
   endfunction : wb_merge

   ////////////////////////////////////////////////////////////////////
   // Declarations
   logic blk_meta_r, blk_sync_r, blk_r;
   logic [19:0] tick_cnt_r;
   logic tick;
   vhzl_phase_t phase_r;
   logic [31:0] quo_r, q_fin;
   logic [16:0] rem_r, rem_sh;
   logic [4:0] dcnt_r;
   logic qbit;
   logic [63:0] meas_r, pretrig_r, pfold_r, pfhold_r;
   logic [15:0] umax_r;
   logic [31:0] vhz_now_r, ratio_r;
   logic [63:0] hist_mem [HD];
   logic [5:0] hp_r;
   logic [7:0] evt_cfg_r;
   logic [15:0] pickup_r;
   logic [18:0] alm_dly_r, op_dly_r;
   vhzl_beh_t beh_set_r;
   logic indiv_r;
   logic [2:0] grp_r;
   logic [3:0] rec_sel_r;
   logic ack_r, wr_en, rd_take, clr_cnt;
   logic [31:0] rd_nxt, wb_new;
   logic pick_r, pick_nxt, pick_on, pick_hold;
   logic start_r, alarm_r, trip_r, blocked_r;
   logic start_nxt, alarm_nxt, trip_nxt, blocked_nxt;
   logic [19:0] elapsed_r, elapsed_nxt;
   logic signed [19:0] remain_r, remain_nxt;
   logic [7:0] evt_raw;
   vhzl_beh_t beh;
   logic blk_eff;
   logic [39:0] lvl;
   vhzl_cond_t cond;
   logic [15:0] cnt_start_r, cnt_trip_r, cnt_blk_r;
   vhzl_rec_t rec_mem [RD];
   vhzl_rec_t rec_new, rec_rd;
   logic [3:0] rec_wp_r, rec_cnt_r;
   logic rec_take;

   ////////////////////////////////////////////////////////////////////
   // Blocking pin synchroniser, first stage read only by the second
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         blk_meta_r <= 1'b0;
         blk_sync_r <= 1'b0;
      end else begin
         blk_meta_r <= BLOCK_IN;
         blk_sync_r <= blk_meta_r;
      end
   end

   // Program cycle timer
   always_ff @(posedge REF_CLK) begin
      if (!RST_N || tick) begin
         tick_cnt_r <= 20'h00000;
      end else begin
         tick_cnt_r <= 20'(tick_cnt_r + 20'h00001);
      end
   end
   assign tick = (tick_cnt_r == 20'(CYC_TICKS - 1));

   // Inputs frozen at cycle start so one cycle sees one consistent set
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         blk_r <= 1'b0;
         meas_r <= 64'h0;
         umax_r <= 16'h0000;
         pretrig_r <= 64'h0;
         pfold_r <= 64'h0;
         hp_r <= 6'h00;
      end else if (tick) begin
         blk_r <= blk_sync_r;
         meas_r <= {U_AB, U_BC, U_CA, FREQ};
         umax_r <= max3(U_AB, U_BC, U_CA);
         pretrig_r <= hist_mem[hist_back(hp_r, 6'(`VHZL_PRE_TRIG_CYC))];
         pfold_r <= hist_mem[hp_r];
         hp_r <= (hp_r == 6'(HD - 1)) ? 6'h00 : 6'(hp_r + 6'h01);
      end
   end

   // History ring; no reset needed, reads before fill return stale data
   always_ff @(posedge REF_CLK) begin
      if (tick) begin
         hist_mem[hp_r] <= {U_AB, U_BC, U_CA, FREQ};
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Shared restoring divider: V/Hz first, then ratio to nominal
   assign rem_sh = {rem_r[15:0], quo_r[31]};
   assign qbit = (rem_sh >= {1'b0, meas_r[15:0]});
   assign q_fin = {quo_r[30:0], qbit};

   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         phase_r <= VHZL_PH_IDLE;
         quo_r <= 32'h0;
         rem_r <= 17'h0;
         dcnt_r <= 5'h00;
         vhz_now_r <= 32'h0;
         ratio_r <= 32'h0;
      end else begin
         case (phase_r)
            VHZL_PH_IDLE: begin
               if (tick) begin
                  phase_r <= VHZL_PH_DIV_VHZ;
               end
               // voltage in milli-pu times 1000 over milli-hertz
               quo_r <= {16'h0, max3(U_AB, U_BC, U_CA)} * 32'd1000;
               rem_r <= 17'h0;
               dcnt_r <= 5'h00;
            end
            VHZL_PH_DIV_VHZ, VHZL_PH_DIV_RAT: begin
               quo_r <= q_fin;
               rem_r <= qbit ? 17'(rem_sh - {1'b0, meas_r[15:0]}) : rem_sh;
               dcnt_r <= 5'(dcnt_r + 5'h01);
               if (dcnt_r == 5'h1F) begin
                  rem_r <= 17'h0;
                  dcnt_r <= 5'h00;
                  if (phase_r == VHZL_PH_DIV_VHZ) begin
                     vhz_now_r <= (meas_r[15:0] == 16'h0) ? 32'h0 : q_fin;
                     quo_r <= {16'h0, umax_r} *
                        32'(`VHZL_NOM_FREQ_MHZ);
                     phase_r <= VHZL_PH_DIV_RAT;
                  end else begin
                     ratio_r <= (meas_r[15:0] == 16'h0) ? 32'h0 : q_fin;
                     phase_r <= VHZL_PH_EVAL;
                  end
               end
            end
            VHZL_PH_EVAL: begin
               phase_r <= VHZL_PH_IDLE;
            end
            default: begin
               phase_r <= VHZL_PH_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Stage decision for the coming program cycle
   always_comb begin
      // mode honoured only with individual setting on
      beh = indiv_r ? beh_set_r : VHZL_BEH_ON;
      blk_eff = blk_r || (beh == VHZL_BEH_BLK) ||
         (beh == VHZL_BEH_TEST_BLK);
      lvl = 40'(`VHZL_FULL_PCT) + {24'h0, pickup_r};
      // ratio in 0.01 percent against limit
      pick_on = ({8'h0, ratio_r} * 40'd10) >= lvl;
      pick_hold = ({8'h0, ratio_r} * 40'd1000) >=
         (lvl * 40'(`VHZL_RESET_PCT));
      pick_nxt = (beh != VHZL_BEH_OFF) && (pick_r ? pick_hold : pick_on);
      start_nxt = 1'b0;
      alarm_nxt = 1'b0;
      trip_nxt = 1'b0;
      blocked_nxt = 1'b0;
      elapsed_nxt = 20'h00000;
      if (pick_nxt && blk_eff) begin
         // running start dropped like a pick-up reset
         blocked_nxt = 1'b1;
      end else if (pick_nxt) begin
         start_nxt = 1'b1;
         // Saturating at the longest delay keeps remaining within range
         if (start_r && elapsed_r < 20'(`VHZL_MAX_DELAY)) begin
            elapsed_nxt = 20'(elapsed_r + 20'h00001);
         end else if (start_r) begin
            elapsed_nxt = elapsed_r;
         end
         alarm_nxt = elapsed_nxt >= {1'b0, alm_dly_r};
         trip_nxt = elapsed_nxt >= {1'b0, op_dly_r};
      end
      // signed, negative once past the delay
      remain_nxt = start_nxt ?
         20'($signed({1'b0, op_dly_r}) - $signed(elapsed_nxt)) : 20'sh0;
      evt_raw = {blocked_r & ~blocked_nxt, ~blocked_r & blocked_nxt,
         trip_r & ~trip_nxt, ~trip_r & trip_nxt,
         alarm_r & ~alarm_nxt, ~alarm_r & alarm_nxt,
         start_r & ~start_nxt, ~start_r & start_nxt};
   end

   // Stage state, updated once per cycle after both divisions
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         pick_r <= 1'b0;
         start_r <= 1'b0;
         alarm_r <= 1'b0;
         trip_r <= 1'b0;
         blocked_r <= 1'b0;
         elapsed_r <= 20'h00000;
         remain_r <= 20'sh0;
      end else if (phase_r == VHZL_PH_EVAL) begin
         pick_r <= pick_nxt;
         start_r <= start_nxt;
         alarm_r <= alarm_nxt;
         trip_r <= trip_nxt;
         blocked_r <= blocked_nxt;
         elapsed_r <= elapsed_nxt;
         remain_r <= remain_nxt;
      end
   end

   assign STAGE_START = start_r;
   assign STAGE_ALARM = alarm_r;
   assign STAGE_TRIP = trip_r;
   assign STAGE_BLOCKED = blocked_r;

   // one of five, most severe shown
   always_comb begin
      if (trip_r) begin
         cond = VHZL_TRIP;
      end else if (alarm_r) begin
         cond = VHZL_ALARM;
      end else if (start_r) begin
         cond = VHZL_START;
      end else if (blocked_r) begin
         cond = VHZL_BLOCKED;
      end else begin
         cond = VHZL_NORMAL;
      end
   end

   // Event strobes toward the event buffer
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         EVT_VALID <= 8'h00;
         EVT_STAMP <= 48'h0;
      end else if (phase_r == VHZL_PH_EVAL) begin
         EVT_VALID <= evt_raw & evt_cfg_r;
         EVT_STAMP <= TIME_MS;
      end else begin
         EVT_VALID <= 8'h00;
      end
   end

   // counters; an occurrence in the clearing cycle is kept
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         cnt_start_r <= 16'h0000;
         cnt_trip_r <= 16'h0000;
         cnt_blk_r <= 16'h0000;
      end else begin
         if (phase_r == VHZL_PH_EVAL && evt_raw[0]) begin
            cnt_start_r <= 16'((clr_cnt ? 16'h0 : cnt_start_r) + 16'h1);
         end else if (clr_cnt) begin
            cnt_start_r <= 16'h0000;
         end
         if (phase_r == VHZL_PH_EVAL && evt_raw[4]) begin
            cnt_trip_r <= 16'((clr_cnt ? 16'h0 : cnt_trip_r) + 16'h1);
         end else if (clr_cnt) begin
            cnt_trip_r <= 16'h0000;
         end
         if (phase_r == VHZL_PH_EVAL && evt_raw[6]) begin
            cnt_blk_r <= 16'((clr_cnt ? 16'h0 : cnt_blk_r) + 16'h1);
         end else if (clr_cnt) begin
            cnt_blk_r <= 16'h0000;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Fault records
   // only ON of start, trip or blocked
   assign rec_take = (phase_r == VHZL_PH_EVAL) &&
      (evt_raw[0] || evt_raw[4] || evt_raw[6]);

   always_comb begin
      // time, event name and three snapshots
      rec_new.stamp = TIME_MS;
      rec_new.pad_lo = 14'h0;
      rec_new.pad_hi = 9'h0;
      rec_new.ev = evt_raw[4] ? 2'h1 : (evt_raw[0] ? 2'h0 : 2'h2);
      rec_new.pretrig = pretrig_r;
      rec_new.fault = meas_r;
      rec_new.prefault = evt_raw[4] ? pfhold_r : pfold_r;
      // remaining time clamped at zero, group as 1..8
      rec_new.remain = remain_nxt[19] ? 19'h0 : remain_nxt[18:0];
      rec_new.grp = 4'({1'b0, grp_r} + 4'h1);
   end

   // Pre-fault snapshot held from start for the later trip record
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         pfhold_r <= 64'h0;
      end else if (phase_r == VHZL_PH_EVAL && evt_raw[0]) begin
         pfhold_r <= pfold_r;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         rec_wp_r <= 4'h0;
         rec_cnt_r <= 4'h0;
      end else if (rec_take) begin
         rec_wp_r <= (rec_wp_r == 4'(RD - 1)) ? 4'h0 : 4'(rec_wp_r + 4'h1);
         if (rec_cnt_r != 4'(RD)) begin
            rec_cnt_r <= 4'(rec_cnt_r + 4'h1);
         end
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (rec_take) begin
         rec_mem[rec_wp_r] <= rec_new;
      end
   end

   // Selected record, zero past the filled depth
   assign rec_rd = (rec_sel_r < rec_cnt_r) ?
      rec_mem[rec_newest(rec_wp_r, rec_sel_r)] : '0;

   ////////////////////////////////////////////////////////////////////
   // Wishbone classic slave, one wait state, write lands at the ack edge
   assign rd_take = WB_CYC_I && WB_STB_I && !ack_r;
   assign wr_en = WB_CYC_I && WB_STB_I && WB_WE_I && ack_r;
   assign clr_cnt = wr_en && WB_SEL_I[0] &&
      (WB_ADR_I == `VHZL_OFF_CTRL) && WB_DAT_I[`VHZL_CTRL_CLR_BIT];
   assign WB_ACK_O = ack_r;
   // Byte lanes merged into the present value, read back through rd_nxt
   assign wb_new = wb_merge(rd_nxt, WB_DAT_I, WB_SEL_I);

   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         ack_r <= 1'b0;
         WB_DAT_O <= 32'h0;
      end else begin
         ack_r <= rd_take;
         if (rd_take) begin
            WB_DAT_O <= rd_nxt;
         end
      end
   end

   // Settings written by software
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         evt_cfg_r <= `VHZL_RST_EVT_CFG;
         pickup_r <= `VHZL_RST_PICKUP;
         alm_dly_r <= `VHZL_RST_DLY;
         op_dly_r <= `VHZL_RST_DLY;
         beh_set_r <= VHZL_BEH_ON;
         indiv_r <= 1'b0;
         grp_r <= `VHZL_RST_GRP;
         rec_sel_r <= 4'h0;
      end else if (wr_en) begin
         case (WB_ADR_I)
            `VHZL_OFF_EVT_CFG: evt_cfg_r <= wb_new[7:0];
            `VHZL_OFF_PICKUP: pickup_r <= wb_new[15:0];
            `VHZL_OFF_ALM_DLY: alm_dly_r <= wb_new[18:0];
            `VHZL_OFF_OP_DLY: op_dly_r <= wb_new[18:0];
            `VHZL_OFF_MODE: begin
               if (WB_SEL_I[0]) begin
                  beh_set_r <= (WB_DAT_I[2:0] > 3'h4) ? VHZL_BEH_ON :
                     vhzl_beh_t'(WB_DAT_I[2:0]);
                  indiv_r <= WB_DAT_I[`VHZL_MODE_INDIV_BIT];
                  grp_r <= WB_DAT_I[`VHZL_MODE_GRP_LSB +: 3];
               end
            end
            `VHZL_OFF_REC_SEL: begin
               if (WB_SEL_I[0]) begin
                  rec_sel_r <= WB_DAT_I[3:0];
               end
            end
            default: begin
            end
         endcase
      end
   end

   // Read decode; unmapped offsets read zero
   always_comb begin
      rd_nxt = 32'h0;
      case (WB_ADR_I)
         `VHZL_OFF_EVT_CFG: rd_nxt = {24'h0, evt_cfg_r};
         `VHZL_OFF_PICKUP: rd_nxt = {16'h0, pickup_r};
         `VHZL_OFF_ALM_DLY: rd_nxt = {13'h0, alm_dly_r};
         `VHZL_OFF_OP_DLY: rd_nxt = {13'h0, op_dly_r};
         `VHZL_OFF_MODE: rd_nxt = {25'h0, grp_r, indiv_r, beh_set_r};
         `VHZL_OFF_STATUS: rd_nxt = {22'h0, blk_r, pick_r, 1'b0, beh,
            1'b0, cond};
         `VHZL_OFF_CNT_START: rd_nxt = {16'h0, cnt_start_r};
         `VHZL_OFF_CNT_TRIP: rd_nxt = {16'h0, cnt_trip_r};
         `VHZL_OFF_CNT_BLK: rd_nxt = {16'h0, cnt_blk_r};
         // present value and ratio in thousandths
         `VHZL_OFF_VHZ_NOW: rd_nxt = vhz_now_r;
         `VHZL_OFF_VHZ_NOM: rd_nxt = 32'(`VHZL_NOM_VHZ);
         `VHZL_OFF_RATIO: rd_nxt = ratio_r;
         // definite time is the expected time
         `VHZL_OFF_EXP_TIME: rd_nxt = {13'h0, op_dly_r};
         `VHZL_OFF_REMAIN: rd_nxt = 32'(remain_r);
         `VHZL_OFF_REC_CNT: rd_nxt = {28'h0, rec_cnt_r};
         `VHZL_OFF_REC_SEL: rd_nxt = {28'h0, rec_sel_r};
         default: begin
            if (WB_ADR_I >= `VHZL_OFF_REC_WIN && WB_ADR_I[1:0] == 2'h0 &&
               WB_ADR_I < 8'(`VHZL_OFF_REC_WIN + 4 * `VHZL_REC_WORDS)) begin
               rd_nxt = rec_rd[32 * 4'(WB_ADR_I[5:2]) +: 32];
            end
         end
      endcase
   end
endmodule : vhzl_logger
`default_nettype wire

// >>> verif/vhzl_logger_chk.sv
// Purpose: port checks of the overexcitation logger
// Assumes: master drops stb after ack
// Notes: events are registered with the stage outputs
`timescale 1ns/1ps
`default_nettype none
module vhzl_logger_chk #(
   parameter int CYC_TICKS = 625000
) (
   input wire logic REF_CLK,
   input wire logic RST_N,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_ACK_O,
   input wire logic [47:0] TIME_MS,
   input wire logic STAGE_START,
   input wire logic STAGE_TRIP,
   input wire logic STAGE_BLOCKED,
   input wire logic [7:0] EVT_VALID,
   input wire logic [47:0] EVT_STAMP
);
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RST_N);
   ////////////////////////////////////////////////////////////////////////
   // Bus answer one cycle after a taken request
   a_ack_follows_req: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O
      |=> WB_ACK_O) else $error("ack missing");
   a_ack_one_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
      else $error("ack too long");
   a_blk_no_start: assert property (STAGE_BLOCKED |-> !STAGE_START)
      else $error("start while blocked");
   a_blk_no_trip: assert property (STAGE_BLOCKED |-> !STAGE_TRIP)
      else $error("trip while blocked");
   // Events must match the edges of the stage outputs
   a_evt_start_on: assert property (EVT_VALID[0] |-> $rose(STAGE_START))
      else $error("start on event wrong");
   a_evt_start_off: assert property (EVT_VALID[1] |-> $fell(STAGE_START))
      else $error("start off event wrong");
   a_evt_trip_on: assert property (EVT_VALID[4] |-> $rose(STAGE_TRIP))
      else $error("trip on event wrong");
   a_evt_blk_on: assert property (EVT_VALID[6] |-> $rose(STAGE_BLOCKED))
      else $error("block on event wrong");
   a_evt_stamp_now: assert property (|EVT_VALID |-> EVT_STAMP ==
      $past(TIME_MS)) else $error("event stamp wrong");
   c_start: cover property ($rose(STAGE_START));
   c_trip: cover property ($rose(STAGE_TRIP));
   c_blk: cover property ($rose(STAGE_BLOCKED));
endmodule : vhzl_logger_chk
bind vhzl_logger vhzl_logger_chk #(.CYC_TICKS(CYC_TICKS)) u_chk (.REF_CLK,
   .RST_N, .WB_CYC_I, .WB_STB_I, .WB_ACK_O, .TIME_MS, .STAGE_START,
   .STAGE_TRIP, .STAGE_BLOCKED, .EVT_VALID, .EVT_STAMP);
`default_nettype wire

// >>> verif/vhzl_far.sv
// Purpose: blocking matrix and event buffer beside the logger
// Assumes: block request comes from the bench
// Notes: counts start ON events that reach the buffer
`timescale 1ns/1ps
`default_nettype none
module vhzl_far (
   input wire logic REF_CLK,
   input wire logic blk_req,
   input wire logic [7:0] EVT_VALID,
   output logic BLOCK_IN,
   output int n_start_on
);
   // block raised well ahead of delay
   always_ff @(posedge REF_CLK) begin
      BLOCK_IN <= blk_req;
      if (EVT_VALID[0] === 1'b1) n_start_on <= n_start_on + 1;
   end
endmodule : vhzl_far
`default_nettype wire

// >>> verif/tb.sv
// Purpose: bench of the overexcitation logger
// Assumes: short program cycle of 100 clocks
// Notes: voltage on one line only, to test the largest wins
`timescale 1ns/1ps
`default_nettype none
module tb;
   import vhzl_pkg::*;
   logic clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, blk_req = 0;
   logic [7:0] adr = 8'h00;
   logic [31:0] dat = 32'h0, q;
   logic [15:0] u_hi = 16'h03E8;
   logic [47:0] t_ms = 48'h0;
   logic [31:0] rdat;
   logic ack, st, al, tr, bl, blk;
   logic [7:0] ev;
   logic [3:0] stg;
   int n_errors = 0, comparisons = 0, n_on;
   vhzl_logger #(.CYC_TICKS(100)) u_vhzl_logger (.REF_CLK(clk),
      .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
      .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(dat), .WB_DAT_O(rdat),
      .WB_ACK_O(ack), .BLOCK_IN(blk), .U_AB(16'h0320), .U_BC(u_hi),
      .U_CA(16'h0320), .FREQ(16'hC350), .TIME_MS(t_ms), .STAGE_START(st),
      .STAGE_ALARM(al), .STAGE_TRIP(tr), .STAGE_BLOCKED(bl),
      .EVT_VALID(ev), .EVT_STAMP());
   vhzl_far u_vhzl_far (.REF_CLK(clk), .blk_req(blk_req), .EVT_VALID(ev),
      .BLOCK_IN(blk), .n_start_on(n_on));
   // Stage outputs as one vector for the wait task
   assign stg = {bl, tr, al, st};
   initial forever #4 clk = ~clk;
   always @(posedge clk) t_ms <= t_ms + 48'h1;
   ////////////////////////////////////////////////////////////////////////
   task automatic results;
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : results
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // One classic cycle; waits for ack, bounded
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
      // Ack and read data are taken at the edge that samples ack high
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      if (ack !== 1'b1) begin
         n_errors++;
         results();
      end
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : wb
   // Waits until one stage output reaches a level
   task automatic wt(input int i, input logic v);
      int n;
      n = 0;
      while (stg[i] !== v && n < 3000) begin
         @(posedge clk);
         n++;
      end
      if (stg[i] !== v) begin
         n_errors++;
         results();
      end
   endtask : wt
   // Fault level: ratio about 1.15 to 1.30 against 1.05 pick-up
   task automatic fault(input logic on);
      @(posedge clk);
      u_hi <= on ? 16'($urandom_range(1150, 1300)) : 16'h03E8;
   endtask : fault
   initial begin
      void'($urandom(32'h3EEA));
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      // Settings and unmapped place after reset
      wb(0, 8'h04, 0); chk(q, 32'h000000FF);
      wb(0, 8'h2C, 0); chk(q, 32'h00000014);
      wb(0, 8'h7C, 0); chk(q, 32'h0);
      wb(1, 8'h0C, 2); wb(1, 8'h10, 3);
      // Behaviour shown only while individual mode is on
      wb(1, 8'h14, 32'h0000000C); wb(0, 8'h18, 0); chk(q[6:4], 3'h4);
      wb(1, 8'h14, 32'h00000004); wb(0, 8'h18, 0); chk(q[6:4], 3'h0);
      wb(1, 8'h14, 0); wb(0, 8'h34, 0); chk(q, 32'h3);
      fault(1); wt(0, 1);
      blk_req <= 1'b1; wt(3, 1); chk(st, 0);
      wb(0, 8'h18, 0); chk(q[2:0], 3'h4);
      // Block released, fault still on: start again and trip
      blk_req <= 1'b0; wt(0, 1); wt(2, 1); chk(al, 1);
      wb(0, 8'h1C, 0); chk(q, 32'h2);
      wb(0, 8'h20, 0); chk(q, 32'h1);
      wb(0, 8'h24, 0); chk(q, 32'h1);
      fault(0); wt(0, 0);
      wb(0, 8'h3C, 0); chk(q, 32'h4);
      wb(0, 8'h84, 0); chk(q[17:16], 2'h1);
      wb(0, 8'hA0, 0); chk(q, 32'h00080000);
      wb(0, 8'h30, 0); chk(q, 32'h000003E8);
      wb(0, 8'h28, 0); chk(q, 32'h00000014);
      wb(0, 8'h38, 0); chk(q, 32'h0);
      wb(1, 8'h00, 1); wb(0, 8'h1C, 0); chk(q, 32'h0);
      repeat (9) begin fault(1); wt(0, 1); fault(0); wt(0, 0); end
      wb(0, 8'h3C, 0); chk(q, 32'hC);
      chk(n_on, 11);
      results();
   end
endmodule : tb
`default_nettype wire
